/* File: include/t16_map.svh */
// Register indices, field positions, reset values and timing counts of the 16-bit timer
`ifndef T16_MAP_SVH
`define T16_MAP_SVH

// Register indices; byte address is four times the index
`define T16_IDX_CTRL_A 10'h080
`define T16_IDX_CTRL_B 10'h081
`define T16_IDX_FORCE 10'h082
`define T16_IDX_COUNT 10'h084
`define T16_IDX_CAPT 10'h086
`define T16_IDX_CMP_A 10'h088
`define T16_IDX_CMP_B 10'h08A
`define T16_IDX_STATUS 10'h090

// Reset values
`define T16_RST_BYTE 8'h00
`define T16_RST_WORD 16'h0000

// Field positions in timer_control_a
`define T16_CA_COM_A_HI 7
`define T16_CA_COM_A_LO 6
`define T16_CA_COM_B_HI 5
`define T16_CA_COM_B_LO 4
`define T16_CA_WGM_HI 1
`define T16_CA_WGM_LO 0

// Field positions in capture_clock_mode_control
`define T16_CB_FILT 7
`define T16_CB_EDGE 6
`define T16_CB_WGM_HI 4
`define T16_CB_WGM_LO 3
`define T16_CB_CS_HI 2
`define T16_CB_CS_LO 0
`define T16_CB_USED_MASK 8'hDF

// Field positions in force_compare_strobes
`define T16_FC_A 7
`define T16_FC_B 6

// Field positions in the status register
`define T16_ST_OVF 0
`define T16_ST_MATCH_A 1
`define T16_ST_MATCH_B 2
`define T16_ST_CAPT 5

// Fixed TOP values and MAX
`define T16_TOP_8 16'h00FF
`define T16_TOP_9 16'h01FF
`define T16_TOP_10 16'h03FF
`define T16_MAX 16'hFFFF

// Prescaler divisors and capture filter depth
`define T16_DIV_8 8
`define T16_DIV_64 64
`define T16_DIV_256 256
`define T16_DIV_1024 1024
`define T16_FILT_LEN 4

`endif

/* File: include/t16_pkg.sv */
// Types shared by the 16-bit timer files
package t16_pkg;
	typedef enum logic [1:0] {TOP_FIXED, TOP_CAPT, TOP_CMPA} t16_top_e;
	typedef enum logic [1:0] {UPD_IMM, UPD_TOP, UPD_BOT} t16_upd_e;
	typedef enum logic [1:0] {OVF_MAX, OVF_TOP, OVF_BOT} t16_ovf_e;
	typedef enum logic {CNT_UP, CNT_DOWN} t16_dir_e;
	typedef struct packed {
		t16_top_e top_src;
		logic [15:0] fixed_top;
		t16_upd_e upd;
		t16_ovf_e ovf;
		logic dual;
		logic pwm;
	} t16_mode_s;
endpackage : t16_pkg

/* File: hw/t16_presc.sv */
// Clock select and prescaler producing the timer count enable
`timescale 1ns/1ps
`default_nettype none
`include "t16_map.svh"
module t16_presc (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [2:0] clock_select,
	input wire logic external_clock_pin,
	output logic tick
);
	logic [9:0] pre_ff;
	logic ext_s1_ff;
	logic ext_s2_ff;
	logic ext_prev_ff;

	////////////////////////////////////////////////////////////////////////
	// Free running divider; shared by all taps so switching taps is glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 10'h000;
		end else if (ce) begin
			pre_ff <= pre_ff + 10'h001;
		end
	end

	// External pin synchronised before edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_ff <= 1'b0;
			ext_s2_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
		end else if (ce) begin
			ext_s1_ff <= external_clock_pin;
			ext_s2_ff <= ext_s1_ff;
			ext_prev_ff <= ext_s2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tap selection
	always_comb begin
		case (clock_select)
			3'h0: tick = 1'b0; // Stopped
			3'h1: tick = ce;
			3'h2: tick = ce && (pre_ff[2:0] == 3'(`T16_DIV_8 - 1));
			3'h3: tick = ce && (pre_ff[5:0] == 6'(`T16_DIV_64 - 1));
			3'h4: tick = ce && (pre_ff[7:0] == 8'(`T16_DIV_256 - 1));
			3'h5: tick = ce && (pre_ff == 10'(`T16_DIV_1024 - 1));
			3'h6: tick = ce && ext_prev_ff && !ext_s2_ff; // Falling
			3'h7: tick = ce && !ext_prev_ff && ext_s2_ff; // Rising
			default: tick = 1'b0;
		endcase
	end
endmodule : t16_presc
`default_nettype wire

/* File: hw/t16_capt.sv */
// Capture input synchroniser, noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none
`include "t16_map.svh"
module t16_capt #(
	parameter int FILT_LEN = `T16_FILT_LEN
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic capture_input_pin,
	input wire logic capture_filter_enable,
	input wire logic capture_edge_select,
	input wire logic capture_enable,
	output logic capture_event
);
	logic s1_ff;
	logic s2_ff;
	logic [FILT_LEN-1:0] hist_ff;
	logic filt_ff;
	logic prev_ff;

	////////////////////////////////////////////////////////////////////////
	// Two stage synchroniser, then a sample history for the filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			hist_ff <= '0;
		end else if (ce) begin
			s1_ff <= capture_input_pin;
			s2_ff <= s1_ff;
			hist_ff <= {hist_ff[FILT_LEN-2:0], s2_ff};
		end
	end

	// Filtered level follows s2_ff with the filter off, else moves only on a run of equal samples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else if (ce) begin
			if (!capture_filter_enable) begin
				filt_ff <= s2_ff;
			end else if (&hist_ff) begin
				filt_ff <= 1'b1;
			end else if (~|hist_ff) begin
				filt_ff <= 1'b0;
			end
			prev_ff <= filt_ff;
		end
	end

	// Edge choice; pin ignored while capture is disconnected
	assign capture_event = ce && capture_enable &&
		(capture_edge_select ? (filt_ff && !prev_ff) : (!filt_ff && prev_ff));
endmodule : t16_capt
`default_nettype wire

/* File: hw/t16_core.sv */
// 16-bit timer/counter core with APB register access
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "t16_map.svh"
module t16_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_pin,
	input wire logic external_clock_pin,
	output logic wave_a,
	output logic wave_b
);
	logic [7:0] timer_control_a_ff;
	logic [7:0] capture_clock_mode_control_ff;
	logic [15:0] counter_value_ff;
	logic [15:0] capture_register_ff;
	logic [15:0] cmp_a_buf_ff;
	logic [15:0] cmp_b_buf_ff;
	logic [15:0] compare_register_a_ff;
	logic [15:0] cmp_b_ff;
	logic overflow_flag_ff;
	logic capture_flag_ff;
	logic match_a_flag_ff;
	logic match_b_flag_ff;
	logic block_match_ff;
	t16_pkg::t16_dir_e dir_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic wave_a_ff;
	logic wave_b_ff;
	logic [3:0] waveform_mode_value;
	t16_pkg::t16_mode_s mode;
	logic [15:0] top;
	logic tick;
	logic capture_event;
	logic at_top;
	logic at_bot;
	logic match_a;
	logic match_b;
	logic upd_now;
	logic ovf_now;
	logic wr;
	logic wr_cnt;
	logic force_compare_a;
	logic force_compare_b;
	logic [9:0] idx;
	logic [15:0] nxt_counter_value;
	t16_pkg::t16_dir_e nxt_dir;

	////////////////////////////////////////////////////////////////////////
	// Mode table; reserved 13 falls to a harmless fixed-MAX default
	function automatic t16_pkg::t16_mode_s decode_mode(input logic [3:0] m);
		t16_pkg::t16_mode_s d;
		d = '{t16_pkg::TOP_FIXED, `T16_MAX, t16_pkg::UPD_IMM, t16_pkg::OVF_MAX, 1'b0, 1'b0};
		case (m)
			4'h0: d.fixed_top = `T16_MAX;
			4'h1, 4'h2, 4'h3: begin
				d.fixed_top = (m == 4'h1) ? `T16_TOP_8 : (m == 4'h2) ? `T16_TOP_9 : `T16_TOP_10;
				d.upd = t16_pkg::UPD_TOP;
				d.ovf = t16_pkg::OVF_BOT;
				d.dual = 1'b1;
				d.pwm = 1'b1;
			end
			4'h4: d.top_src = t16_pkg::TOP_CMPA;
			4'hC: d.top_src = t16_pkg::TOP_CAPT;
			4'h5, 4'h6, 4'h7: begin
				d.fixed_top = (m == 4'h5) ? `T16_TOP_8 : (m == 4'h6) ? `T16_TOP_9 : `T16_TOP_10;
				d.upd = t16_pkg::UPD_BOT;
				d.ovf = t16_pkg::OVF_TOP;
				d.pwm = 1'b1;
			end
			4'h8, 4'h9, 4'hA, 4'hB: begin
				d.top_src = m[0] ? t16_pkg::TOP_CMPA : t16_pkg::TOP_CAPT;
				d.upd = m[1] ? t16_pkg::UPD_TOP : t16_pkg::UPD_BOT;
				d.ovf = t16_pkg::OVF_BOT;
				d.dual = 1'b1;
				d.pwm = 1'b1;
			end
			4'hE, 4'hF: begin
				d.top_src = m[0] ? t16_pkg::TOP_CMPA : t16_pkg::TOP_CAPT;
				d.upd = t16_pkg::UPD_BOT;
				d.ovf = t16_pkg::OVF_TOP;
				d.pwm = 1'b1;
			end
			default: d.upd = t16_pkg::UPD_IMM;
		endcase
		return d;
	endfunction : decode_mode

	// Next output level of one waveform channel
	function automatic logic wave_next(input logic cur, input logic [1:0] com,
			input logic hit, input logic bot, input logic down, input logic tog_ok);
		logic r;
		r = cur;
		if (!mode.pwm) begin
			if (hit) begin
				r = (com == 2'h1) ? !cur : (com == 2'h2) ? 1'b0 : (com == 2'h3) ? 1'b1 : cur;
			end
		end else if (com[1]) begin
			if (hit) begin
				r = com[0] ^ (mode.dual && down);
			end else if (bot && !mode.dual) begin
				r = !com[0];
			end
		end else if (com[0] && tog_ok && hit) begin
			r = !cur;
		end
		return r;
	endfunction : wave_next

	////////////////////////////////////////////////////////////////////////
	// Mode, TOP and event decode
	assign waveform_mode_value = {capture_clock_mode_control_ff[`T16_CB_WGM_HI:`T16_CB_WGM_LO],
		timer_control_a_ff[`T16_CA_WGM_HI:`T16_CA_WGM_LO]};
	assign mode = decode_mode(waveform_mode_value);
	assign top = (mode.top_src == t16_pkg::TOP_CMPA) ? compare_register_a_ff :
		(mode.top_src == t16_pkg::TOP_CAPT) ? capture_register_ff : mode.fixed_top;
	assign at_top = (counter_value_ff == top);
	assign at_bot = (counter_value_ff == `T16_RST_WORD);
	assign match_a = tick && !block_match_ff && (counter_value_ff == compare_register_a_ff);
	assign match_b = tick && !block_match_ff && (counter_value_ff == cmp_b_ff);
	assign upd_now = (mode.upd == t16_pkg::UPD_TOP) ? (tick && at_top) :
		(mode.upd == t16_pkg::UPD_BOT) ? (tick && at_bot) : 1'b0;
	assign ovf_now = (mode.ovf == t16_pkg::OVF_MAX) ? (tick && counter_value_ff == `T16_MAX) :
		(mode.ovf == t16_pkg::OVF_TOP) ? (tick && at_top) :
		(tick && at_bot && dir_ff == t16_pkg::CNT_DOWN);

	// APB decode; write lands on the access edge
	assign idx = paddr[11:2];
	assign wr = ce && psel && penable && pready_ff && pwrite;
	assign wr_cnt = wr && (idx == `T16_IDX_COUNT);
	// Strobes only act in non-PWM modes
	assign force_compare_a = wr && (idx == `T16_IDX_FORCE) && pwdata[`T16_FC_A] && !mode.pwm;
	assign force_compare_b = wr && (idx == `T16_IDX_FORCE) && pwdata[`T16_FC_B] && !mode.pwm;

	////////////////////////////////////////////////////////////////////////
	// Timer clock source and capture front end
	t16_presc u_presc (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.clock_select(capture_clock_mode_control_ff[`T16_CB_CS_HI:`T16_CB_CS_LO]),
		.external_clock_pin(external_clock_pin),
		.tick(tick)
	);

	t16_capt #(.FILT_LEN(`T16_FILT_LEN)) u_capt (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.capture_input_pin(capture_input_pin),
		.capture_filter_enable(capture_clock_mode_control_ff[`T16_CB_FILT]),
		.capture_edge_select(capture_clock_mode_control_ff[`T16_CB_EDGE]),
		.capture_enable(mode.top_src != t16_pkg::TOP_CAPT),
		.capture_event(capture_event)
	);

	////////////////////////////////////////////////////////////////////////
	// Counting sequence: single slope wraps at TOP, dual slope turns round
	always_comb begin
		nxt_counter_value = counter_value_ff;
		nxt_dir = dir_ff;
		case (dir_ff)
			t16_pkg::CNT_UP: begin
				if (mode.dual && at_top) begin
					nxt_counter_value = counter_value_ff - 16'h0001;
					nxt_dir = t16_pkg::CNT_DOWN;
				end else if (at_top) begin
					nxt_counter_value = `T16_RST_WORD;
				end else begin
					nxt_counter_value = counter_value_ff + 16'h0001;
				end
			end
			t16_pkg::CNT_DOWN: begin
				if (at_bot || !mode.dual) begin
					nxt_counter_value = mode.dual ? 16'h0001 : counter_value_ff + 16'h0001;
					nxt_dir = t16_pkg::CNT_UP;
				end else begin
					nxt_counter_value = counter_value_ff - 16'h0001;
				end
			end
			default: nxt_dir = t16_pkg::CNT_UP;
		endcase
	end

	// Counter moves only on a tick; a bus write wins and masks next match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_value_ff <= `T16_RST_WORD;
			dir_ff <= t16_pkg::CNT_UP;
			block_match_ff <= 1'b0;
		end else if (ce) begin
			if (wr_cnt) begin
				counter_value_ff <= pwdata[15:0];
				block_match_ff <= 1'b1;
			end else if (tick) begin
				counter_value_ff <= nxt_counter_value;
				dir_ff <= nxt_dir;
				block_match_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers and compare buffers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_a_ff <= `T16_RST_BYTE;
			capture_clock_mode_control_ff <= `T16_RST_BYTE;
			cmp_a_buf_ff <= `T16_RST_WORD;
			cmp_b_buf_ff <= `T16_RST_WORD;
		end else if (wr) begin
			case (idx)
				`T16_IDX_CTRL_A: timer_control_a_ff <= pwdata[7:0];
				`T16_IDX_CTRL_B: capture_clock_mode_control_ff <= pwdata[7:0] & `T16_CB_USED_MASK;
				`T16_IDX_CMP_A: cmp_a_buf_ff <= pwdata[15:0];
				`T16_IDX_CMP_B: cmp_b_buf_ff <= pwdata[15:0];
				default: cmp_b_buf_ff <= cmp_b_buf_ff;
			endcase
		end
	end

	// Active compare values: immediate in non-PWM, else at the update point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_register_a_ff <= `T16_RST_WORD;
			cmp_b_ff <= `T16_RST_WORD;
		end else if (ce) begin
			if (mode.upd == t16_pkg::UPD_IMM || upd_now) begin
				compare_register_a_ff <= cmp_a_buf_ff;
				cmp_b_ff <= cmp_b_buf_ff;
			end
		end
	end

	// Capture register: copy on event, else writable by software in any mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_register_ff <= `T16_RST_WORD;
		end else if (ce) begin
			if (capture_event) begin
				capture_register_ff <= counter_value_ff;
			end else if (wr && idx == `T16_IDX_CAPT) begin
				capture_register_ff <= pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags, write one to clear; a same-cycle event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow_flag_ff <= 1'b0;
			match_a_flag_ff <= 1'b0;
			match_b_flag_ff <= 1'b0;
			capture_flag_ff <= 1'b0;
		end else if (ce) begin
			if (wr && idx == `T16_IDX_STATUS) begin
				overflow_flag_ff <= overflow_flag_ff & !pwdata[`T16_ST_OVF];
				match_a_flag_ff <= match_a_flag_ff & !pwdata[`T16_ST_MATCH_A];
				match_b_flag_ff <= match_b_flag_ff & !pwdata[`T16_ST_MATCH_B];
				capture_flag_ff <= capture_flag_ff & !pwdata[`T16_ST_CAPT];
			end
			if (ovf_now) overflow_flag_ff <= 1'b1;
			if (match_a) match_a_flag_ff <= 1'b1; // Forced compare never lands here
			if (match_b) match_b_flag_ff <= 1'b1;
			if (capture_event) capture_flag_ff <= 1'b1;
		end
	end

	// Waveform outputs; a forced compare acts like a match on the output only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_a_ff <= 1'b0;
			wave_b_ff <= 1'b0;
		end else if (ce) begin
			wave_a_ff <= wave_next(wave_a_ff,
				timer_control_a_ff[`T16_CA_COM_A_HI:`T16_CA_COM_A_LO], match_a || force_compare_a,
				tick && at_bot, dir_ff == t16_pkg::CNT_DOWN, mode.top_src == t16_pkg::TOP_CMPA);
			wave_b_ff <= wave_next(wave_b_ff,
				timer_control_a_ff[`T16_CA_COM_B_HI:`T16_CA_COM_B_LO], match_b || force_compare_b,
				tick && at_bot, dir_ff == t16_pkg::CNT_DOWN, 1'b0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB answer: ready and data prepared in setup, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (ce) begin
			pready_ff <= psel && !penable;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			if (psel && !penable) begin
				case (idx)
					`T16_IDX_CTRL_A: prdata_ff[7:0] <= timer_control_a_ff;
					`T16_IDX_CTRL_B: prdata_ff[7:0] <= capture_clock_mode_control_ff;
					`T16_IDX_FORCE: prdata_ff <= 32'h0000_0000;
					`T16_IDX_COUNT: prdata_ff[15:0] <= counter_value_ff;
					`T16_IDX_CAPT: prdata_ff[15:0] <= capture_register_ff;
					`T16_IDX_CMP_A: prdata_ff[15:0] <= cmp_a_buf_ff;
					`T16_IDX_CMP_B: prdata_ff[15:0] <= cmp_b_buf_ff;
					`T16_IDX_STATUS: prdata_ff[7:0] <= {2'h0, capture_flag_ff, 2'h0,
						match_b_flag_ff, match_a_flag_ff, overflow_flag_ff};
					default: pslverr_ff <= 1'b1;
				endcase
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign wave_a = wave_a_ff;
	assign wave_b = wave_b_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks; frozen cycles are excluded since state holds then
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	normal_wrap_a: assert property (waveform_mode_value == 4'h0 && tick && !wr_cnt &&
		counter_value_ff == `T16_MAX |=> counter_value_ff == 16'h0000 && overflow_flag_ff)
		else $error("normal mode did not wrap with overflow");
	phase_turn_a: assert property (waveform_mode_value == 4'h1 && tick && !wr_cnt &&
		counter_value_ff == 16'h00FF && dir_ff == t16_pkg::CNT_UP
		|=> counter_value_ff == 16'h00FE)
		else $error("phase correct did not turn at top");
	match_clear_a: assert property (waveform_mode_value == 4'h4 && tick && !wr_cnt &&
		counter_value_ff == compare_register_a_ff |=> counter_value_ff == 16'h0000)
		else $error("clear on match failed");
	fast_ovf_a: assert property (waveform_mode_value == 4'h5 && tick &&
		counter_value_ff == 16'h00FF |=> overflow_flag_ff)
		else $error("fast pwm overflow missing");
	capt_copy_a: assert property (capture_event |=> capture_flag_ff &&
		capture_register_ff == $past(counter_value_ff))
		else $error("capture copy wrong");
	capt_off_a: assert property (mode.top_src == t16_pkg::TOP_CAPT |-> !capture_event)
		else $error("capture active while register is top");
	stop_hold_a: assert property (capture_clock_mode_control_ff[2:0] == 3'h0 && !wr_cnt
		|=> $stable(counter_value_ff))
		else $error("counter moved while stopped");
	force_read_a: assert property (psel && !penable && idx == `T16_IDX_FORCE
		|=> prdata_ff == 32'h0000_0000)
		else $error("force strobes read non-zero");
	force_quiet_a: assert property (force_compare_a && !match_a && !match_a_flag_ff
		|=> !match_a_flag_ff)
		else $error("forced compare raised a flag");

	capt_seen_c: cover property (capture_event);
	pwm_turn_c: cover property (mode.dual && tick && at_top);
	force_hit_c: cover property (force_compare_a);
endmodule : t16_core
`default_nettype wire

/* File: tb/timer16_mode_clock_capture_tb_top.sv */
// Self-checking bench for the 16-bit timer core
`timescale 1ns/1ps
`default_nettype none
`include "t16_map.svh"
module timer16_mode_clock_capture_tb_top;
	typedef struct packed {
		logic [7:0] ca;
		logic [7:0] cb;
		logic [15:0] st;
		logic [15:0] top;
		logic ovf;
	} t16_row_s;
	localparam logic [9:0] i_ca = `T16_IDX_CTRL_A;
	localparam logic [9:0] i_cb = `T16_IDX_CTRL_B;
	localparam logic [9:0] i_fc = `T16_IDX_FORCE;
	localparam logic [9:0] i_cnt = `T16_IDX_COUNT;
	localparam logic [9:0] i_st = `T16_IDX_STATUS;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, wave_a, wave_b;
	logic cap_pin = 1'b0;
	logic ext_pin = 1'b1;
	logic ce = 1'b1;
	logic [31:0] v, w;
	logic [1:0] pw;
	logic e;
	int n_errors = 0;
	int samples_checked = 0;
	int dv [5] = '{1, `T16_DIV_8, `T16_DIV_64, `T16_DIV_256, `T16_DIV_1024};
	t16_row_s rows [6];

	// Free-running 20 MHz clock
	always #25 pclk = ~pclk;

	t16_core DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(cap_pin), .external_clock_pin(ext_pin),
		.wave_a(wave_a), .wave_b(wave_b));

	////////////////////////////////////////////////////////////////////////
	// Bus cycles, waits and comparisons
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// Request held until pready is seen; only the watchdog ends a dead wait
	task automatic apb(input logic wr, input logic [9:0] i, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so the next call never drives psel twice in one step
		@(posedge pclk);
	endtask : apb

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask : chk_bit

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	// Watchdog, well beyond the slowest prescaler test
	initial begin
		cyc(20000);
		n_errors++;
		wrap_up();
	end

	// Main sequence; mode 13 is never programmed
	initial begin
		rows[0] = '{8'h00, 8'h01, 16'hFFFA, 16'hFFFF, 1'b1};
		rows[1] = '{8'h01, 8'h01, 16'h00FA, 16'h00FF, 1'b0};
		rows[2] = '{8'h01, 8'h09, 16'h00FA, 16'h00FF, 1'b1};
		rows[3] = '{8'h00, 8'h09, 16'h0000, 16'h0009, 1'b0};
		rows[4] = '{8'h01, 8'h11, 16'h0000, 16'h0009, 1'b1};
		rows[5] = '{8'h03, 8'h19, 16'h0000, 16'h0009, 1'b1};
		cyc(4);
		presetn <= 1'b1;
		apb(0, i_cb, 32'h0);
		chk_val(v, 32'h0);
		apb(1, i_cb, 32'hFF);
		apb(0, i_cb, 32'h0);
		chk_val(v, 32'hDF);
		apb(1, i_fc, 32'hC0);
		apb(0, i_fc, 32'h0);
		chk_val(v, 32'h0);
		apb(0, 10'h3FF, 32'h0);
		chk_bit(e, 1'b1);
		$display("registers done");
		// Mode rows: counter stays at or under TOP, overflow flag per mode
		foreach (rows[k]) begin
			apb(1, i_cb, 32'h0);
			apb(1, i_ca, 32'h0);
			apb(1, `T16_IDX_CMP_A, 32'h9);
			apb(1, i_st, 32'h27);
			apb(1, i_cnt, {16'h0, rows[k].st});
			apb(1, i_ca, {24'h0, rows[k].ca});
			apb(1, i_cb, {24'h0, rows[k].cb});
			repeat (6) begin
				cyc(5);
				apb(0, i_cnt, 32'h0);
				chk_bit(v[15:0] <= rows[k].top, 1'b1);
			end
			apb(0, i_st, 32'h0);
			chk_bit(v[0], rows[k].ovf);
		end
		$display("modes done");
		// Prescaler: ticks over 4 periods plus the three-cycle read gap, less one wait
		apb(1, i_cb, 32'h0);
		apb(1, i_ca, 32'h0);
		for (int c = 1; c < 6; c++) begin
			apb(1, i_cb, c);
			apb(0, i_cnt, 32'h0);
			w = v;
			cyc(4 * dv[c - 1] - 1);
			apb(0, i_cnt, 32'h0);
			chk_bit((v - w) inside {[4:6]}, 1'b1);
		end
		// Clock enable low freezes the counter; only the three enabled edges count
		apb(1, i_cb, 32'h1);
		apb(0, i_cnt, 32'h0);
		w = v;
		ce <= 1'b0;
		cyc(20);
		ce <= 1'b1;
		apb(0, i_cnt, 32'h0);
		chk_val(v - w, 32'h3);
		apb(1, i_cb, 32'h0);
		apb(0, i_cnt, 32'h0);
		w = v;
		cyc(20);
		apb(0, i_cnt, 32'h0);
		chk_val(v, w);
		// External pin: three pulses give three edges of either kind
		for (int c = 6; c < 8; c++) begin
			apb(1, i_cb, c);
			apb(0, i_cnt, 32'h0);
			w = v;
			repeat (3) begin
				ext_pin <= 1'b0;
				cyc(4);
				ext_pin <= 1'b1;
				cyc(4);
			end
			cyc(4);
			apb(0, i_cnt, 32'h0);
			chk_val(v - w, 32'h3);
		end
		$display("clock select done");
		// Capture on each edge polarity with the counter stopped
		for (int s = 0; s < 2; s++) begin
			cap_pin <= (s == 0);
			apb(1, i_cb, {25'h0, s[0], 6'h0});
			cyc(8);
			apb(1, i_st, 32'h27);
			apb(1, i_cnt, 32'h40 + s);
			cap_pin <= (s != 0);
			cyc(8);
			apb(0, `T16_IDX_CAPT, 32'h0);
			chk_val(v, 32'h40 + s);
			apb(0, i_st, 32'h0);
			chk_bit(v[5], 1'b1);
		end
		// Filter drops a two-cycle glitch but passes a long level
		apb(1, i_cb, 32'hC0);
		apb(1, i_st, 32'h27);
		cap_pin <= 1'b0;
		cyc(2);
		cap_pin <= 1'b1;
		cyc(12);
		apb(0, i_st, 32'h0);
		chk_bit(v[5], 1'b0);
		cap_pin <= 1'b0;
		cyc(8);
		cap_pin <= 1'b1;
		cyc(12);
		apb(0, i_st, 32'h0);
		chk_bit(v[5], 1'b1);
		// Capture register as TOP ignores the pin
		apb(1, i_cb, 32'h58);
		apb(1, i_st, 32'h27);
		cap_pin <= 1'b0;
		cyc(8);
		cap_pin <= 1'b1;
		cyc(12);
		apb(0, i_st, 32'h0);
		chk_bit(v[5], 1'b0);
		$display("capture done");
		// Force strobes in clear-on-match mode, then in fast PWM
		apb(1, i_cb, 32'h08);
		apb(1, i_ca, 32'h50);
		apb(1, i_cnt, 32'h33);
		apb(1, i_st, 32'h27);
		pw = {wave_a, wave_b};
		apb(1, i_fc, 32'h80);
		cyc(2);
		chk_val({30'h0, wave_a, wave_b}, {30'h0, ~pw[1], pw[0]});
		apb(1, i_fc, 32'h40);
		cyc(2);
		chk_val({30'h0, wave_a, wave_b}, {30'h0, ~pw});
		apb(0, i_cnt, 32'h0);
		chk_val(v, 32'h33);
		apb(0, i_st, 32'h0);
		chk_val(v & 32'h7, 32'h0);
		apb(1, i_ca, 32'h51);
		pw = {wave_a, wave_b};
		apb(1, i_fc, 32'hC0);
		cyc(2);
		chk_val({30'h0, wave_a, wave_b}, {30'h0, pw});
		$display("force done");
		// Second reset in mid-run clears the control registers
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		apb(0, i_ca, 32'h0);
		chk_val(v, 32'h0);
		$display("reset done");
		wrap_up();
	end
endmodule : timer16_mode_clock_capture_tb_top
`default_nettype wire
